// [rtl/hci_host.sv]
// host-side controller driving the sampling converter through its pins
`timescale 1ns/10ps
`default_nettype none
module hci_host
    import hci_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // user side
    input wire logic startReq,
    output logic startReady,
    input wire logic cfgWriteStart,
    input wire logic cfgEarlyRead,
    input wire logic cfgStandAlone,
    output logic [RES_W-1:0] result,
    output logic resultValid,
    output logic timedOut,
    // converter pins
    output logic modeStrap,
    output logic chipSelectN,
    output logic readStrobeN,
    input wire logic sharedIn,
    output logic sharedOut,
    output logic sharedOe,
    input wire logic convDoneN,
    input wire logic [RES_W-1:0] resultBus
);
    typedef struct packed {
        hci_state_type state;
        logic [CW-1:0] cnt;
        logic mode;
        logic early;
        logic alone;
        logic relSeen;
        logic csN;
        logic rdN;
        logic wrN;
        logic wrOe;
        logic [RES_W-1:0] res;
        logic resValid;
        logic tmo;
    } hci_host_type;

    hci_host_type s_r;
    hci_host_type s_nxt;
    logic [1:0] ctlSync;
    logic [RES_W-1:0] busSync;
    logic releaseHigh;
    logic doneLow;
    logic cntZero;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    hci_sync2 #(.W(2)) ctlSyncInst (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pinIn({sharedIn, convDoneN}),
        .syncOut(ctlSync)
    );

    // data is read the access time after read falls, read-start at the release, stand-alone STAND_ALONE_CYC after write rises
    hci_sync2 #(.W(RES_W)) busSyncInst (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pinIn(resultBus),
        .syncOut(busSync)
    );

    assign releaseHigh = ctlSync[1];
    assign doneLow = !ctlSync[0];
    assign cntZero = (s_r.cnt == CNT_ZERO);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.resValid = 1'b0;
        if (!cntZero)
        begin
            s_nxt.cnt = s_r.cnt - CNT_ONE;
        end
        case (s_r.state)
            ST_IDLE:
            begin
                // start taken the very cycle it is asked, so timer jitter is not added
                if (startReq)
                begin
                    s_nxt.mode = cfgWriteStart;
                    s_nxt.early = cfgEarlyRead;
                    s_nxt.alone = cfgWriteStart && cfgStandAlone;
                    s_nxt.tmo = 1'b0;
                    s_nxt.relSeen = 1'b0;
                    s_nxt.csN = 1'b0;
                    if (cfgWriteStart)
                    begin
                        // write fall under select starts conversion
                        s_nxt.wrN = 1'b0;
                        s_nxt.wrOe = 1'b1;
                        s_nxt.rdN = !cfgStandAlone;
                        s_nxt.cnt = WR_PULSE_CYC;
                        s_nxt.state = ST_WRITE;
                    end
                    else
                    begin
                        // one read starts and fetches the conversion
                        s_nxt.rdN = 1'b0;
                        s_nxt.wrOe = 1'b0;
                        s_nxt.cnt = DONE_TIMEOUT_CYC;
                        s_nxt.state = ST_READ;
                    end
                end
            end
            ST_WRITE:
            begin
                if (cntZero)
                begin
                    s_nxt.wrN = 1'b1;
                    s_nxt.state = ST_WAIT;
                    if (s_r.alone)
                    begin
                        s_nxt.cnt = STAND_ALONE_CYC;
                    end
                    else if (s_r.early)
                    begin
                        s_nxt.cnt = EARLY_READ_CYC;
                    end
                    else
                    begin
                        s_nxt.cnt = DONE_TIMEOUT_CYC;
                    end
                end
            end
            ST_WAIT:
            begin
                if (s_r.alone && cntZero)
                begin
                    // bus already enabled: take data and stay selected
                    s_nxt.res = busSync;
                    s_nxt.resValid = 1'b1;
                    s_nxt.cnt = CONV_GAP_CYC;
                    s_nxt.state = ST_GAP;
                end
                else if (!s_r.alone && (cntZero || (!s_r.early && doneLow)))
                begin
                    // early option ignores done; wait option falls back to timeout
                    s_nxt.tmo = cntZero && !s_r.early;
                    s_nxt.rdN = 1'b0;
                    s_nxt.cnt = DATA_ACCESS_CYC;
                    s_nxt.state = ST_READ;
                end
            end
            ST_READ:
            begin
                // release must be seen low first: just after the start the synchroniser still shows idle high
                s_nxt.relSeen = s_r.relSeen || !releaseHigh;
                if (cntZero || ((s_r.mode == MODE_READ_START) && s_r.relSeen && releaseHigh))
                begin
                    // read-start without a release is a timeout; write-start keeps its wait verdict
                    s_nxt.tmo = s_r.tmo || ((s_r.mode == MODE_READ_START) && !(s_r.relSeen && releaseHigh));
                    s_nxt.res = busSync;
                    s_nxt.resValid = 1'b1;
                    s_nxt.csN = 1'b1;
                    s_nxt.rdN = 1'b1;
                    s_nxt.cnt = CONV_GAP_CYC;
                    s_nxt.state = ST_GAP;
                end
            end
            ST_GAP:
            begin
                // input tracking time before the next start
                if (cntZero)
                begin
                    s_nxt.state = ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r.state <= ST_IDLE;
            s_r.cnt <= CNT_ZERO;
            s_r.mode <= MODE_READ_START;
            s_r.early <= 1'b0;
            s_r.alone <= 1'b0;
            s_r.relSeen <= 1'b0;
            s_r.csN <= 1'b1;
            s_r.rdN <= 1'b1;
            s_r.wrN <= 1'b1;
            s_r.wrOe <= 1'b0;
            s_r.res <= '0;
            s_r.resValid <= 1'b0;
            s_r.tmo <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign startReady = (s_r.state == ST_IDLE);
    assign modeStrap = s_r.mode;
    assign chipSelectN = s_r.csN;
    assign readStrobeN = s_r.rdN;
    assign sharedOut = s_r.wrN;
    assign sharedOe = s_r.wrOe; // never drive the open-drain wait line
    assign result = s_r.res;
    assign resultValid = s_r.resValid;
    assign timedOut = s_r.tmo;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CW-1:0] wrLowCnt;
    logic [CW-1:0] sinceWrRise;
    logic [CW-1:0] sinceEnd;

    // helper counters: sinceWrRise and sinceEnd saturate, wrLowCnt wraps
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrLowCnt <= CNT_ZERO;
            sinceWrRise <= CNT_MAX;
            sinceEnd <= CNT_MAX;
        end
        else
        begin
            wrLowCnt <= s_r.wrN ? CNT_ZERO : wrLowCnt + CNT_ONE;
            sinceWrRise <= (!s_r.wrN && s_nxt.wrN) ? CNT_ZERO :
                ((sinceWrRise == CNT_MAX) ? CNT_MAX : sinceWrRise + CNT_ONE);
            sinceEnd <= s_r.resValid ? CNT_ONE :
                ((sinceEnd == CNT_MAX) ? CNT_MAX : sinceEnd + CNT_ONE);
        end
    end

    localparam int SA_DATA_DLY = STAND_ALONE_CYC + CNT_ONE;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_wr_under_select: assert property ($fell(sharedOut) |-> !chipSelectN && sharedOe)
        else $error("write strobe fell without chip select");
    a_wr_pulse_width: assert property ($rose(sharedOut) |-> $past(wrLowCnt) >= WR_PULSE_CYC)
        else $error("write pulse shorter than required");
    a_pin_role_mode: assert property (sharedOe == (modeStrap == MODE_WRITE_START) || startReady)
        else $error("shared pin driven in read-start mode");
    a_early_read_delay: assert property ($fell(readStrobeN) && modeStrap |-> sinceWrRise >= EARLY_READ_CYC)
        else $error("read lowered too soon after write");
    a_read_start_hold: assert property (s_r.state == ST_READ && !modeStrap && !releaseHigh && !cntZero
        |=> !chipSelectN && !readStrobeN)
        else $error("select or read released before end of conversion");
    a_conv_gap: assert property ($fell(startReady) |-> sinceEnd > CONV_GAP_CYC)
        else $error("conversions spaced too closely");
    a_stand_alone_hold: assert property (s_r.alone && !startReady |-> !chipSelectN && !readStrobeN)
        else $error("stand-alone select or read released");
    a_stand_alone_data: assert property (s_r.alone && $rose(sharedOut) |-> ##SA_DATA_DLY resultValid)
        else $error("stand-alone data not taken on time");
    a_result_source: assert property (resultValid |-> result == $past(busSync))
        else $error("result differs from sampled bus");

    c_read_start: cover property (resultValid && !modeStrap);
    c_early_read: cover property (resultValid && modeStrap && s_r.early && !s_r.alone);
    c_wait_done: cover property (resultValid && modeStrap && !s_r.early && !timedOut);
    c_stand_alone: cover property (resultValid && s_r.alone);
endmodule : hci_host
`default_nettype wire

// [rtl/hci_pkg.sv]
// constants, timing counts and state types for the converter host controller
package hci_pkg;

    // ------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CW = 8;
    localparam int RES_W = 8;

    // ------------------------------------------------------------
    // timing figures in nanoseconds
    // ------------------------------------------------------------
    localparam int WR_PULSE_NS = 250;
    localparam int EARLY_READ_NS = 250;
    localparam int DATA_ACCESS_NS = 160;
    localparam int STAND_ALONE_NS = 530;
    localparam int CONV_GAP_NS = 350;
    localparam int DONE_TIMEOUT_NS = 1500;

    // least time to whole cycles, never below one
    function automatic logic [CW-1:0] minCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return c[CW-1:0];
    endfunction : minCycles

    localparam logic [CW-1:0] WR_PULSE_CYC = minCycles(WR_PULSE_NS);
    localparam logic [CW-1:0] EARLY_READ_CYC = minCycles(EARLY_READ_NS);
    localparam logic [CW-1:0] DATA_ACCESS_CYC = minCycles(DATA_ACCESS_NS);
    localparam logic [CW-1:0] STAND_ALONE_CYC = minCycles(STAND_ALONE_NS);
    localparam logic [CW-1:0] CONV_GAP_CYC = minCycles(CONV_GAP_NS);
    localparam logic [CW-1:0] DONE_TIMEOUT_CYC = minCycles(DONE_TIMEOUT_NS);
    localparam logic [CW-1:0] CNT_ZERO = 8'h00;
    localparam logic [CW-1:0] CNT_ONE = 8'h01;
    localparam logic [CW-1:0] CNT_MAX = 8'hff;

    // ------------------------------------------------------------
    // mode strap levels and sequencer states
    // ------------------------------------------------------------
    localparam logic MODE_READ_START = 1'b0;
    localparam logic MODE_WRITE_START = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WRITE = 3'h1,
        ST_WAIT = 3'h3,
        ST_READ = 3'h2,
        ST_GAP = 3'h6
    } hci_state_type;

endpackage : hci_pkg

// [rtl/hci_sync2.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module hci_sync2
#(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // pin side and synchronised side
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } hci_sync_type;

    hci_sync_type s_r;
    hci_sync_type s_nxt;

    // first stage feeds only the second
    always_comb
    begin
        s_nxt.stage1 = pinIn;
        s_nxt.stage2 = s_r.stage1;
    end

    // reset to all ones: the pins sampled here idle high
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.stage2;
endmodule : hci_sync2
`default_nettype wire

// [verification/hci_conv_model.sv]
// behavioural model of the sampling converter as seen at its pins
`timescale 1ns/10ps
`default_nettype none
module hci_conv_model
#(
    parameter int CONV_NS = 600,
    parameter int DONE_NS = 380
)
(
    // strap and strobes from the host
    input wire logic modeStrap,
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    // analog stand-in and fault control
    input wire logic [7:0] sampleCode,
    input wire logic holdBusy,
    // converter outputs
    output logic relLow,
    output logic convDoneN,
    output logic [7:0] resultBus
);
    // ------------------------------------------------------------
    // conversion state
    // ------------------------------------------------------------
    logic [7:0] held;
    logic [7:0] latchQ;
    logic pending;
    logic selRd;

    assign selRd = chipSelectN | readStrobeN;

    initial
    begin
        relLow = 1'b0;
        convDoneN = 1'b1;
        latchQ = 8'h00;
        pending = 1'b0;
    end

    // read-start begins here; early read in write-start loads the latch
    // 1 ns settle: strap and strobes may move at the same host edge
    always @(negedge selRd)
    begin
        #1;
        if (modeStrap == 1'b0)
        begin
            held = sampleCode;
            relLow = 1'b1;
            #(CONV_NS);
            if (!holdBusy)
            begin
                latchQ = held;
                relLow = 1'b0;
                convDoneN = 1'b0;
            end
        end
        else if (pending && writeStrobeN)
        begin
            latchQ = held;
            pending = 1'b0;
            convDoneN = 1'b0;
        end
    end

    // write fall under select starts, internal time-out latches the result
    always @(negedge writeStrobeN)
    begin
        #1;
        if (modeStrap && !chipSelectN)
        begin
            held = sampleCode;
            pending = 1'b1;
            @(posedge writeStrobeN);
            #(DONE_NS);
            if (pending && !holdBusy)
            begin
                latchQ = held;
                pending = 1'b0;
                convDoneN = 1'b0;
            end
        end
    end

    // flag clears on select or read rising
    always @(posedge chipSelectN or posedge readStrobeN)
    begin
        convDoneN = 1'b1;
    end

    // a floating bus shows the inverse, never stale data
    assign resultBus = (selRd == 1'b0) ? latchQ : ~latchQ;
endmodule : hci_conv_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the converter host controller
`timescale 1ns/10ps
`default_nettype none
module tb import hci_pkg::*;;
    // ------------------------------------------------------------
    // signals, rows and instances
    // ------------------------------------------------------------
    logic clk_sys, arst_n, startReq, startReady, cfgWriteStart, cfgEarlyRead, cfgStandAlone;
    logic resultValid, timedOut, modeStrap, chipSelectN, readStrobeN, sharedOut, sharedOe;
    logic convDoneN, relLow, holdBusy, sharedWire;
    logic [RES_W-1:0] result, resultBus, sampleCode;
    int errTotal = 0;
    int comparisons = 0;
    int cycles = 0;
    // write-start, early read, stand-alone, code that must come back
    logic [10:0] rows [5] = '{{3'b000, 8'h00}, {3'b000, 8'hff}, {3'b100, 8'ha5}, {3'b110, 8'h5a}, {3'b101, 8'h3c}};

    // release line has a pull-up; host drives the pin in write-start
    assign sharedWire = sharedOe ? sharedOut : !relLow;

    hci_host u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .startReq(startReq), .startReady(startReady),
        .cfgWriteStart(cfgWriteStart), .cfgEarlyRead(cfgEarlyRead), .cfgStandAlone(cfgStandAlone),
        .result(result), .resultValid(resultValid), .timedOut(timedOut), .modeStrap(modeStrap),
        .chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .sharedIn(sharedWire), .sharedOut(sharedOut),
        .sharedOe(sharedOe), .convDoneN(convDoneN), .resultBus(resultBus));

    hci_conv_model u_conv (.modeStrap(modeStrap), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .writeStrobeN(sharedWire), .sampleCode(sampleCode), .holdBusy(holdBusy), .relLow(relLow),
        .convDoneN(convDoneN), .resultBus(resultBus));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // request one conversion, then move the input past its sampling edge
    task automatic start(input logic [10:0] row);
        {cfgWriteStart, cfgEarlyRead, cfgStandAlone, sampleCode} = row;
        startReq = 1'b1;
        tick(1);
        startReq = 1'b0;
        tick(4);
        sampleCode = ~row[7:0];
        check("chip select", 8'(chipSelectN), 8'h00);
        check("mode strap", 8'(modeStrap), 8'(row[10]));
        check("read strobe", 8'(readStrobeN), 8'(row[10] & ~row[8]));
        check("shared pin", 8'(sharedWire), 8'h00);
    endtask : start

    // wait the answer, then poke the settle gap with an early request
    task automatic finishRow(input logic [10:0] row);
        int n;
        n = 0;
        while (resultValid !== 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        check("result", result, row[7:0]);
        check("timed out", 8'(timedOut), 8'h00);
        startReq = 1'b1;
        tick(30);
        check("gap ready", 8'(startReady), 8'h00);
        check("gap select", 8'(chipSelectN), 8'(!row[8]));
        startReq = 1'b0;
        tick(10);
        check("ready after gap", 8'(startReady), 8'h01);
    endtask : finishRow

    // ------------------------------------------------------------
    // sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errTotal++;
            $display("[FAIL] cycle limit expected 4999 seen 5000");
            summarize();
        end
    end

    initial
    begin
        int n;
        arst_n = 1'b0;
        startReq = 1'b0;
        cfgWriteStart = 1'b0;
        cfgEarlyRead = 1'b0;
        cfgStandAlone = 1'b0;
        holdBusy = 1'b0;
        sampleCode = 8'h00;
        tick(16);
        arst_n = 1'b1;
        foreach (rows[i])
        begin
            start(rows[i]);
            finishRow(rows[i]);
            $display("row %0d finished", i);
        end
        // mid-run reset: stand-alone leaves strobes low, reset must lift them
        arst_n = 1'b0;
        tick(2);
        check("reset select", 8'(chipSelectN), 8'h01);
        check("reset read", 8'(readStrobeN), 8'h01);
        check("reset drive", 8'(sharedOe), 8'h00);
        check("reset strap", 8'(modeStrap), 8'h00);
        check("reset ready", 8'(startReady), 8'h01);
        check("reset result", result, 8'h00);
        arst_n = 1'b1;
        tick(2);
        $display("reset test finished");
        // converter never finishes: the host has to give up by itself
        holdBusy = 1'b1;
        start(11'h011);
        n = 0;
        while (timedOut !== 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        check("timeout flag", 8'(timedOut), 8'h01);
        holdBusy = 1'b0;
        n = 0;
        while (startReady !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        start(11'h081);
        finishRow(11'h081);
        $display("timeout test finished");
        summarize();
    end
endmodule : tb
`default_nettype wire
